// ### ptb_time_base.sv
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/10ps
module ptb_time_base #(
    parameter int WIDE = 0,
    parameter int N_CH = ptb_pkg::N_CH_DEF,
    parameter int CW   = (WIDE != 0) ? ptb_pkg::CNT_W_WIDE : ptb_pkg::CNT_W_NARROW
) (
    input  wire logic                             i_ref_clk,
    input  wire logic                             i_nrst,
    input  wire logic [7:0]                       i_addr,
    input  wire logic [31:0]                      i_wdata,
    input  wire logic                             i_wr,
    input  wire logic                             i_rd,
    input  wire logic                             i_sync,
    output logic      [31:0]                      o_rdata,
    output logic      [CW-1:0]                    o_count,
    output logic                                  o_count_down,
    output logic                                  o_update_pulse,
    output logic      [N_CH-1:0]                  o_compare_match_pulse,
    output logic      [N_CH*ptb_pkg::MODE_W-1:0]  o_channel_output_mode,
    output logic      [ptb_pkg::OEP_W-1:0]        o_output_enable_polarity_word
);

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    ptb_pkg::ptb_bus_s bus;
    assign bus = '{rd: i_rd, wr: i_wr, addr: i_addr, wdata: i_wdata};

    logic [15:0]       timer_control_one;
    logic [ptb_pkg::PSC_W-1:0] prescale_divider;
    logic [CW-1:0]     init_count;
    logic [CW-1:0]     period_reload_input;
    logic [CW-1:0]     period_reload_value;
    logic [CW-1:0]     cmp_pre [N_CH];
    logic [CW-1:0]     channel_compare_value [N_CH];
    logic [ptb_pkg::MODE_W-1:0] mode_pre [N_CH];
    logic [ptb_pkg::MODE_W-1:0] mode_act [N_CH];
    logic [ptb_pkg::PSC_W-1:0] psc_cnt;
    logic [CW-1:0]     count;
    logic              dn;
    logic              sync_m;
    logic              sync_s;
    logic              sync_d;
    logic              upd_seen;

    wire wr_ctrl   = bus.wr && (bus.addr == ptb_pkg::A_CTRL);
    wire wr_psc    = bus.wr && (bus.addr == ptb_pkg::A_PSC);
    wire wr_period = bus.wr && (bus.addr == ptb_pkg::A_PERIOD);
    wire wr_oep    = bus.wr && (bus.addr == ptb_pkg::A_OEP);
    wire wr_init   = bus.wr && (bus.addr == ptb_pkg::A_INITCNT);

    wire [1:0] alignment_select = timer_control_one[ptb_pkg::CTL_CMS +: 2];
    wire       edge_mode        = (alignment_select == ptb_pkg::PTB_EDGE);
    wire       edge_down        = timer_control_one[ptb_pkg::CTL_DIR];
    wire       counter_run_enable = timer_control_one[ptb_pkg::CTL_CEN];
    wire       update_disable   = timer_control_one[ptb_pkg::CTL_UPDATE_DISABLE];
    // deadtime_clock_divide is stored but never read by the counter

    // ------------------------------------------------------------------
    // prescaler
    // ------------------------------------------------------------------
    // compare with >= so a divider written below the running count cannot stall
    wire tick = counter_run_enable && (psc_cnt >= prescale_divider);

    // ------------------------------------------------------------------
    // counter next state
    // ------------------------------------------------------------------
    wire at_top = (count >= period_reload_value);
    wire at_bot = (count == '0);
    logic [CW-1:0] next_count;
    logic          next_dn;
    logic          wrap;

    always_comb begin
        next_count = count;
        next_dn    = dn;
        wrap       = 1'b0;
        if (edge_mode) begin
            next_dn = edge_down;
            if (!edge_down) begin
                if (at_top) begin
                    next_count = '0;
                    wrap       = 1'b1;
                end else begin
                    next_count = count + 1'b1;
                end
            end else begin
                if (at_bot) begin
                    next_count = period_reload_value;
                    wrap       = 1'b1;
                end else begin
                    next_count = count - 1'b1;
                end
            end
        end else begin
            // up to reload then down to zero, 2*reload ticks per cycle
            if (!dn) begin
                if (at_top) begin
                    next_count = count - 1'b1;
                    next_dn    = 1'b1;
                    wrap       = 1'b1;
                end else begin
                    next_count = count + 1'b1;
                end
            end else begin
                if (at_bot) begin
                    next_count = count + 1'b1;
                    next_dn    = 1'b0;
                    wrap       = 1'b1;
                end else begin
                    next_count = count - 1'b1;
                end
            end
        end
    end

    // every wrap is an update unless update_disable is set, no repetition or one-shot
    wire update_event      = tick && wrap && !update_disable;
    wire sync_rise = sync_s && !sync_d;
    wire load_cfg = update_event || sync_rise;

    // compare gating by count direction in center modes
    wire flag_ok = edge_mode
                   || (alignment_select == ptb_pkg::PTB_CTR_BO)
                   || ((alignment_select == ptb_pkg::PTB_CTR_DN) && dn)
                   || ((alignment_select == ptb_pkg::PTB_CTR_UP) && !dn);

    // ------------------------------------------------------------------
    // sync input synchroniser
    // ------------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            sync_m <= 1'b0;
            sync_s <= 1'b0;
            sync_d <= 1'b0;
        end else begin
            sync_m <= i_sync;
            sync_s <= sync_m;
            sync_d <= sync_s;
        end
    end

    // ------------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            timer_control_one   <= ptb_pkg::CTL_RESET;
            prescale_divider    <= '0;
            init_count          <= '0;
            period_reload_input <= '0;
        end else begin
            if (wr_ctrl) begin
                timer_control_one <= bus.wdata[15:0];
            end
            if (wr_psc) begin
                prescale_divider <= bus.wdata[ptb_pkg::PSC_W-1:0];
            end
            if (wr_init) begin
                init_count <= bus.wdata[CW-1:0];
            end
            if (wr_period) begin
                period_reload_input <= bus.wdata[CW-1:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // output enable and polarity word, not preloaded
    // ------------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            o_output_enable_polarity_word <= '0;
        end else if (wr_oep) begin
            o_output_enable_polarity_word <= bus.wdata[ptb_pkg::OEP_W-1:0];
        end
    end

    // ------------------------------------------------------------------
    // start-up load of the initial count and direction
    // ------------------------------------------------------------------
    // the load repeats after a write of the initial count, so software
    // can place the counter without another reset
    wire start_load = !upd_seen;

    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            upd_seen <= 1'b0;
        end else begin
            upd_seen <= !wr_init;
        end
    end

    // ------------------------------------------------------------------
    // prescaler count
    // ------------------------------------------------------------------
    wire                      psc_clear = start_load || sync_rise || tick;
    wire [ptb_pkg::PSC_W-1:0] psc_inc   = psc_cnt + 1'b1;

    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            psc_cnt <= '0;
        end else if (psc_clear) begin
            psc_cnt <= '0;
        end else if (counter_run_enable) begin
            psc_cnt <= psc_inc;
        end
    end

    // ------------------------------------------------------------------
    // counter and direction
    // ------------------------------------------------------------------
    // a sync keeps the direction; the next tick turns it at the bottom
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            count <= '0;
            dn    <= 1'b0;
        end else if (start_load) begin
            count <= init_count;
            dn    <= timer_control_one[ptb_pkg::CTL_INIT_DN];
        end else if (sync_rise) begin
            count <= '0;
        end else if (tick) begin
            count <= next_count;
            dn    <= next_dn;
        end
    end

    // ------------------------------------------------------------------
    // update pulse and active period
    // ------------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            o_update_pulse      <= 1'b0;
            period_reload_value <= '0;
        end else begin
            o_update_pulse <= update_event;
            if (load_cfg) begin
                period_reload_value <= period_reload_input;
            end
        end
    end

    // ------------------------------------------------------------------
    // per channel compare, all output compare
    // ------------------------------------------------------------------
    for (genvar c = 0; c < N_CH; c++) begin : g_ch
        localparam logic [7:0] CMP_A  = 8'(ptb_pkg::A_CMP0 + 4 * c);
        localparam logic [7:0] MODE_A = 8'(ptb_pkg::A_MODE0 + 4 * c);
        wire wr_cmp  = bus.wr && (bus.addr == CMP_A);
        wire wr_mode = bus.wr && (bus.addr == MODE_A);
        wire hit     = tick && flag_ok && (count == channel_compare_value[c]);

        // preload stage, written by the bus at any time
        always_ff @(posedge i_ref_clk) begin
            if (!i_nrst) begin
                cmp_pre[c]  <= '0;
                mode_pre[c] <= '0;
            end else begin
                if (wr_cmp) begin
                    cmp_pre[c] <= bus.wdata[CW-1:0];
                end
                if (wr_mode) begin
                    mode_pre[c] <= bus.wdata[ptb_pkg::MODE_W-1:0];
                end
            end
        end

        // active stage, moved across only at an update or a sync
        always_ff @(posedge i_ref_clk) begin
            if (!i_nrst) begin
                channel_compare_value[c] <= '0;
                mode_act[c]              <= '0;
            end else if (load_cfg) begin
                channel_compare_value[c] <= cmp_pre[c];
                mode_act[c]              <= mode_pre[c];
            end
        end

        always_ff @(posedge i_ref_clk) begin
            if (!i_nrst) begin
                o_compare_match_pulse[c] <= 1'b0;
            end else begin
                o_compare_match_pulse[c] <= hit;
            end
        end
        assign o_channel_output_mode[c*ptb_pkg::MODE_W +: ptb_pkg::MODE_W] = mode_act[c];
    end

    // ------------------------------------------------------------------
    // read back
    // ------------------------------------------------------------------
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = '0;
        case (bus.addr)
            ptb_pkg::A_CTRL:    rd_mux = {16'h0000, timer_control_one};
            ptb_pkg::A_PSC:     rd_mux = 32'(prescale_divider);
            ptb_pkg::A_PERIOD:  rd_mux = 32'(period_reload_value);
            ptb_pkg::A_OEP:     rd_mux = o_output_enable_polarity_word;
            ptb_pkg::A_STATUS:  rd_mux = {31'h00000000, dn};
            ptb_pkg::A_COUNT:   rd_mux = 32'(count);
            ptb_pkg::A_INITCNT: rd_mux = 32'(init_count);
            default:            rd_mux = '0;
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            o_rdata      <= '0;
            o_count      <= '0;
            o_count_down <= 1'b0;
        end else begin
            o_rdata      <= bus.rd ? rd_mux : '0;
            o_count      <= count;
            o_count_down <= dn;
        end
    end

endmodule

// ### ptb_pkg.sv
package ptb_pkg;

    // ------------------------------------------------------------------
    // widths and counts
    // ------------------------------------------------------------------
    localparam int CNT_W_WIDE   = 32;
    localparam int CNT_W_NARROW = 16;
    localparam int N_CH_DEF     = 4;
    localparam int PSC_W        = 16;
    localparam int MODE_W       = 4;
    localparam int OEP_W        = 32;

    // ------------------------------------------------------------------
    // register offsets (byte addressed, one word apart)
    // ------------------------------------------------------------------
    localparam logic [7:0] A_CTRL    = 8'h00;
    localparam logic [7:0] A_PSC     = 8'h04;
    localparam logic [7:0] A_PERIOD  = 8'h08;
    localparam logic [7:0] A_OEP     = 8'h0c;
    localparam logic [7:0] A_STATUS  = 8'h10;
    localparam logic [7:0] A_COUNT   = 8'h14;
    localparam logic [7:0] A_INITCNT = 8'h18;
    localparam logic [7:0] A_CMP0    = 8'h20;
    localparam logic [7:0] A_MODE0   = 8'h40;

    // ------------------------------------------------------------------
    // timer_control_one field positions
    // ------------------------------------------------------------------
    localparam int CTL_CEN  = 0;
    localparam int CTL_UPDATE_DISABLE = 1;
    localparam int CTL_DIR  = 4;
    localparam int CTL_CMS  = 5;
    localparam int CTL_RELOAD_PRELOAD_ENABLE = 7;
    localparam int CTL_CKD  = 8;
    localparam int CTL_INIT_DN = 15;
    localparam logic [15:0] CTL_RESET = 16'h0081;

    // ------------------------------------------------------------------
    // alignment select encodings
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PTB_EDGE   = 2'b00,
        PTB_CTR_DN = 2'b01,
        PTB_CTR_UP = 2'b10,
        PTB_CTR_BO = 2'b11
    } ptb_align_e;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [31:0] wdata;
    } ptb_bus_s;

endpackage

// ### ptb_time_base_properties.sv
`timescale 1ns/10ps
module ptb_time_base_properties #(
    parameter int WIDE = 0,
    parameter int N_CH = 4,
    parameter int CW   = 16
) (
    input wire logic              i_ref_clk,
    input wire logic              i_nrst,
    input wire logic [7:0]        i_addr,
    input wire logic [31:0]       i_wdata,
    input wire logic              i_wr,
    input wire logic              i_sync,
    input wire logic [CW-1:0]     o_count,
    input wire logic              o_count_down,
    input wire logic              o_update_pulse,
    input wire logic [N_CH-1:0]   o_compare_match_pulse,
    input wire logic [N_CH*4-1:0] o_channel_output_mode,
    input wire logic [31:0]       o_output_enable_polarity_word
);
    logic [3:0] sync_win;
    wire        quiet = (sync_win == 4'h0);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);
    // a sync edge crosses two flops, so skip step checks for a while
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst)
            sync_win <= 4'h0;
        else if (i_sync)
            sync_win <= 4'hf;
        else if (!quiet)
            sync_win <= sync_win - 4'h1;
    end
    sequence held_in_reset;
        !i_nrst ##1 !i_nrst;
    endsequence
    // ------------
    // assertions
    // ------------
    AST_RESET_QUIET: assert property (disable iff (1'b0) held_in_reset |=>
        o_count == '0 && !o_update_pulse && o_compare_match_pulse == '0)
        else $error("outputs active in reset");
    AST_UPDATE_SINGLE: assert property (
        o_update_pulse && o_count != '0 |=> !o_update_pulse) else $error("long update");
    AST_MATCH_SINGLE: assert property (
        o_compare_match_pulse[0] && $changed(o_count) |=> !o_compare_match_pulse[0])
        else $error("long match");
    AST_UP_STEP: assert property ($changed(o_count) && quiet && !o_count_down
        && $stable(o_count_down) && !$past(o_count_down, 2)
        |-> o_count == $past(o_count) + 1'b1 || o_count == '0) else $error("bad up step");
    AST_DOWN_STEP: assert property ($changed(o_count) && quiet && o_count_down
        && $stable(o_count_down) && $past(o_count_down, 2)
        |-> o_count == $past(o_count) - 1'b1 || $past(o_count) == '0)
        else $error("bad down step");
    AST_WRAP_UPDATE: assert property (
        quiet && !o_count_down && o_count == '0 && $past(o_count) > 1
        |-> $past(o_update_pulse) or ##[0:2] o_update_pulse) else $error("wrap no update");
    AST_OEP_NOW: assert property (i_wr && i_addr == ptb_pkg::A_OEP |=>
        o_output_enable_polarity_word == $past(i_wdata)) else $error("enable word late");
    AST_MODE_AT_UPDATE: assert property ($changed(o_channel_output_mode) && quiet
        |-> $past(o_update_pulse) or ##[0:1] o_update_pulse) else $error("mode not preloaded");
endmodule
bind ptb_time_base ptb_time_base_properties #(.WIDE(WIDE), .N_CH(N_CH), .CW(CW))
    ptb_time_base_properties_inst (.i_ref_clk, .i_nrst, .i_addr, .i_wdata, .i_wr, .i_sync,
    .o_count, .o_count_down, .o_update_pulse, .o_compare_match_pulse,
    .o_channel_output_mode, .o_output_enable_polarity_word);

// ### ptb_oc_model.sv
`timescale 1ns/10ps
module ptb_oc_model (
    input  wire logic       i_ref_clk,
    input  wire logic       i_nrst,
    input  wire logic       i_match,
    input  wire logic [3:0] i_mode,
    input  wire logic       i_invert,
    output logic            o_pin
);
    logic ref_level;
    // toggle mode flips the reference on every compare hit
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst)
            ref_level <= 1'b0;
        else if (i_match && i_mode == 4'h3)
            ref_level <= ~ref_level;
    end
    assign o_pin = ref_level ^ i_invert;
endmodule

// ### test_ptb_time_base.sv
`timescale 1ns/10ps
module test_ptb_time_base;
    logic        i_ref_clk, i_nrst, i_wr, i_rd, i_sync, o_count_down, o_update_pulse, pin;
    logic [7:0]  i_addr;
    logic [31:0] i_wdata, o_rdata, o_output_enable_polarity_word;
    logic [15:0] o_count, o_channel_output_mode;
    logic [3:0]  o_compare_match_pulse;
    int          n_mismatch = 0, checks_done = 0, cycles = 0, gap = 0, last = 0, hitc = 0;

    ptb_time_base ptb_time_base_inst (.i_ref_clk, .i_nrst, .i_addr, .i_wdata, .i_wr, .i_rd,
        .i_sync, .o_rdata, .o_count, .o_count_down, .o_update_pulse, .o_compare_match_pulse,
        .o_channel_output_mode, .o_output_enable_polarity_word);
    ptb_oc_model ptb_oc_model_inst (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
        .i_match(o_compare_match_pulse[0]), .i_mode(o_channel_output_mode[3:0]),
        .i_invert(o_output_enable_polarity_word[1]), .o_pin(pin));

    initial begin
        i_ref_clk = 1'b0;
        forever #12.5 i_ref_clk = ~i_ref_clk;
    end
    // gap between update pulses and running count of channel 0 compare hits
    always @(posedge i_ref_clk) begin
        cycles <= cycles + 1;
        if (o_update_pulse === 1'b1) begin
            gap  <= cycles - last;
            last <= cycles;
        end
        if (o_compare_match_pulse[0] === 1'b1)
            hitc <= hitc + 1;
        if (cycles == 3000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    // ------------
    // tasks
    // ------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic rnw, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_ref_clk);
        {i_rd, i_wr, i_addr, i_wdata} <= {rnw, !rnw, a, d};
        @(posedge i_ref_clk);
        {i_rd, i_wr} <= 2'b00;
        #1;
        if (rnw)
            chk(o_rdata, d);
    endtask
    task automatic setup(input logic [31:0] ctl);
        @(posedge i_ref_clk);
        i_nrst <= 1'b0;
        repeat (20) @(posedge i_ref_clk);
        i_nrst <= 1'b1;
        bus(1'b0, ptb_pkg::A_CTRL, ctl);
        bus(1'b0, ptb_pkg::A_PSC, 32'h2);
        bus(1'b0, ptb_pkg::A_PERIOD, 32'h4);
        bus(1'b0, ptb_pkg::A_CMP0, 32'h2);
        @(posedge i_ref_clk);
        i_sync <= 1'b1;
        repeat (4) @(posedge i_ref_clk);
        i_sync <= 1'b0;
    endtask
    task automatic t_regs();
        bus(1'b1, ptb_pkg::A_CTRL, {16'h0, ptb_pkg::CTL_RESET});
        bus(1'b1, ptb_pkg::A_INITCNT, 32'h0);
        bus(1'b0, 8'h3c, 32'hffff_ffff);
        bus(1'b1, 8'h3c, 32'h0);
        bus(1'b0, ptb_pkg::A_CTRL, 32'h8000);
        bus(1'b0, ptb_pkg::A_INITCNT, 32'h3);
        bus(1'b1, ptb_pkg::A_COUNT, 32'h3);
        bus(1'b1, ptb_pkg::A_STATUS, 32'h1);
        bus(1'b0, ptb_pkg::A_OEP, 32'h2);
        chk(o_output_enable_polarity_word, 32'h2);
        chk({31'h0, pin}, 32'h1);
    endtask
    task automatic t_mode(input logic [31:0] ctl, input int gp, input int w, input int hx);
        int c;
        setup(ctl);
        repeat (40) @(posedge i_ref_clk);
        #1;
        c = hitc;
        repeat (w) @(posedge i_ref_clk);
        #1;
        chk(gap, gp);
        chk(hitc - c, hx);
        if (ctl[6:5] == 2'b00)
            chk({31'h0, o_count_down}, {31'h0, ctl[4]});
    endtask
    task automatic t_preload();
        logic p;
        setup(32'h81);
        @(posedge i_ref_clk iff o_update_pulse === 1'b1);
        bus(1'b0, ptb_pkg::A_PERIOD, 32'h9);
        bus(1'b0, ptb_pkg::A_MODE0, 32'h3);
        chk(32'(o_channel_output_mode), 32'h0);
        bus(1'b1, ptb_pkg::A_PERIOD, 32'h4);
        repeat (70) @(posedge i_ref_clk);
        #1;
        chk(gap, 32'd30);
        chk(32'(o_channel_output_mode), 32'h3);
        p = pin;
        repeat (30) @(posedge i_ref_clk);
        #1;
        chk({31'h0, pin}, {31'h0, ~p});
    endtask
    task automatic report_and_stop();
        if (n_mismatch == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        {i_nrst, i_wr, i_rd, i_sync, i_addr, i_wdata} = '0;
        repeat (20) @(posedge i_ref_clk);
        i_nrst <= 1'b1;
        t_regs();
        t_mode(32'h81, 15, 30, 2);
        t_mode(32'h91, 15, 30, 2);
        t_mode(32'ha1, 12, 24, 1);
        t_mode(32'hc1, 12, 24, 1);
        t_mode(32'he1, 12, 24, 2);
        t_preload();
        report_and_stop();
    end
endmodule
